// [core/autoneg_ability_regs.sv]
// Behaviour
// - Host writable advertised ability, fixed field layout
// - Read-only partner ability, same layout
// - Expansion high byte reads all zero
// - Expansion low reserved and next-page bits zero
// - Page received latches, clears on host read
// - Extended high byte: only bit seven set
// - Extended low byte zero, writes ignored
`timescale 1ns/10ps
`default_nettype none
module autoneg_ability_regs (
    input wire logic CLOCK,
    input wire logic RESET,
    input wire ability_pkg::host_req_t HOST_REQ,
    output logic [7:0] HOST_RDATA,
    output logic HOST_RVALID,
    input wire logic PAGE_RX_STB,
    input wire logic [15:0] PAGE_RX_WORD,
    output ability_pkg::ability_t ADV_ABILITY,
    output ability_pkg::ability_t PARTNER_ABILITY,
    output logic PAGE_RX_FLAG
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ability_pkg::ability_t adv_ff;
    ability_pkg::ability_t partner;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic page_flag_q;
    logic wr_adv_high;
    logic wr_adv_low;
    logic rd_exp_low;
    logic [7:0] adv_high_byte;
    logic [7:0] adv_low_byte;

    // ------------------------------------------------------------
    // Host decode
    // ------------------------------------------------------------
    // Writes to any offset other than the advertised pair are dropped
    assign wr_adv_high = HOST_REQ.wr &&
                         HOST_REQ.addr == ability_pkg::OFS_ADV_HIGH;
    assign wr_adv_low = HOST_REQ.wr &&
                        HOST_REQ.addr == ability_pkg::OFS_ADV_LOW;
    assign rd_exp_low = HOST_REQ.rd &&
                        HOST_REQ.addr == ability_pkg::OFS_EXP_LOW;

    assign adv_high_byte = ability_pkg::pack_high(adv_ff);
    assign adv_low_byte = ability_pkg::pack_low(adv_ff);

    // ------------------------------------------------------------
    // Advertised ability pair
    // ------------------------------------------------------------
    // Each byte writes only its own fields; the other byte is kept
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            adv_ff <= ability_pkg::unpack(ability_pkg::ADV_HIGH_RESET,
                                          ability_pkg::ADV_LOW_RESET);
        end else if (wr_adv_high) begin
            adv_ff <= ability_pkg::unpack(HOST_REQ.wdata,
                                          adv_low_byte);
        end else if (wr_adv_low) begin
            adv_ff <= ability_pkg::unpack(adv_high_byte,
                                          HOST_REQ.wdata);
        end
    end

    assign ADV_ABILITY = adv_ff;

    // ------------------------------------------------------------
    // Partner page and page-received flag
    // ------------------------------------------------------------
    // Both load on the same strobe so software never sees a stale page
    partner_capture partner_capture_inst (
        .clock(CLOCK),
        .reset(RESET),
        .load(PAGE_RX_STB),
        .page_word(PAGE_RX_WORD),
        .partner(partner)
    );

    page_flag page_flag_inst (
        .clock(CLOCK),
        .reset(RESET),
        .set_pulse(PAGE_RX_STB),
        .clear_pulse(rd_exp_low),
        .flag(page_flag_q)
    );

    assign PARTNER_ABILITY = partner;
    assign PAGE_RX_FLAG = page_flag_q;

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------
    // Unmapped offsets return zero rather than stale data
    always_comb begin
        nxt_rdata = ability_pkg::BYTE_ZERO;
        case (HOST_REQ.addr)
            ability_pkg::OFS_ADV_HIGH: begin
                nxt_rdata = adv_high_byte;
            end
            ability_pkg::OFS_ADV_LOW: begin
                nxt_rdata = adv_low_byte;
            end
            ability_pkg::OFS_LP_HIGH: begin
                nxt_rdata = ability_pkg::pack_high(partner);
            end
            ability_pkg::OFS_LP_LOW: begin
                nxt_rdata = ability_pkg::pack_low(partner);
            end
            ability_pkg::OFS_EXP_HIGH: begin
                nxt_rdata = ability_pkg::EXP_HIGH_VALUE;
            end
            ability_pkg::OFS_EXP_LOW: begin
                // Next-page able stays zero: no next-page support
                nxt_rdata[ability_pkg::BIT_PAGE_RX] = page_flag_q;
            end
            ability_pkg::OFS_EXT_HIGH: begin
                nxt_rdata = ability_pkg::EXT_HIGH_VALUE;
            end
            ability_pkg::OFS_EXT_LOW: begin
                nxt_rdata = ability_pkg::EXT_LOW_VALUE;
            end
            default: begin
                nxt_rdata = ability_pkg::BYTE_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    // Data is captured with the read, so the flag shows its pre-clear value
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rdata_ff <= ability_pkg::BYTE_ZERO;
        end else if (HOST_REQ.rd) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Valid marks the cycle after each read
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= HOST_REQ.rd;
        end
    end

    assign HOST_RDATA = rdata_ff;
    assign HOST_RVALID = rvalid_ff;

    // ------------------------------------------------------------
    // Assertions: advertised pair
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);

    // Write then read back the high byte over the bus
    adv_high_write_a: assert property (
        HOST_REQ.wr && HOST_REQ.addr == ability_pkg::OFS_ADV_HIGH
        ##1 HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_ADV_HIGH
        && !HOST_REQ.wr
        |=> HOST_RDATA == ($past(HOST_REQ.wdata, 2)
                           & ability_pkg::HIGH_FIELD_MASK))
        else $error("advertised high byte not written back");

    adv_low_write_a: assert property (
        wr_adv_low |=> adv_low_byte ==
            ($past(HOST_REQ.wdata) & ability_pkg::LOW_FIELD_MASK))
        else $error("advertised low byte fields wrong");

    // The byte not written keeps its fields
    adv_high_keep_a: assert property (
        wr_adv_low |=> adv_high_byte == $past(adv_high_byte))
        else $error("advertised high byte changed by low write");

    adv_low_keep_a: assert property (
        wr_adv_high |=> adv_low_byte == $past(adv_low_byte))
        else $error("advertised low byte changed by high write");

    // Writes anywhere else must leave the advertised pair alone
    adv_ro_keep_a: assert property (
        HOST_REQ.wr && !wr_adv_high && !wr_adv_low |=> $stable(adv_ff))
        else $error("advertised pair changed by other write");

    // ------------------------------------------------------------
    // Assertions: partner pair
    // ------------------------------------------------------------

    // Partner bytes carry field bits only
    partner_read_a: assert property (
        HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_LP_HIGH
        |=> HOST_RVALID
        && (HOST_RDATA & ~ability_pkg::HIGH_FIELD_MASK) == 8'h00)
        else $error("partner high byte has non-field bits");

    partner_ro_a: assert property (
        HOST_REQ.wr && !PAGE_RX_STB
        && (HOST_REQ.addr == ability_pkg::OFS_LP_LOW
            || HOST_REQ.addr == ability_pkg::OFS_LP_HIGH)
        |=> $stable(partner))
        else $error("partner ability changed by host write");

    partner_low_read_a: assert property (
        HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_LP_LOW
        |=> HOST_RVALID
        && (HOST_RDATA & ~ability_pkg::LOW_FIELD_MASK) == 8'h00)
        else $error("partner low byte has non-field bits");

    // Only a received page may change the partner pair
    partner_hold_a: assert property (
        !PAGE_RX_STB |=> $stable(partner))
        else $error("partner ability changed without a page");

    // ------------------------------------------------------------
    // Assertions: expansion pair
    // ------------------------------------------------------------

    // Expansion high byte is reserved throughout
    exp_high_zero_a: assert property (
        HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_EXP_HIGH
        |=> HOST_RDATA == 8'h00)
        else $error("expansion high byte not zero");

    exp_low_fixed_a: assert property (
        HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_EXP_LOW
        |=> HOST_RDATA[7:2] == 6'h00 && HOST_RDATA[0] == 1'b0)
        else $error("expansion low fixed bits not zero");

    page_set_a: assert property (
        PAGE_RX_STB ##1 !rd_exp_low |=> PAGE_RX_FLAG)
        else $error("page flag not set or not held");

    // A read shows the flag, then clears it
    page_clear_a: assert property (
        PAGE_RX_FLAG && rd_exp_low && !PAGE_RX_STB
        |=> HOST_RDATA[ability_pkg::BIT_PAGE_RX] && !PAGE_RX_FLAG)
        else $error("page flag read did not clear");

    // Read data stands, so the pre-clear flag is not lost
    rdata_hold_a: assert property (
        !HOST_REQ.rd |=> $stable(HOST_RDATA))
        else $error("read data changed without a read");

    // Without a read the flag stays up
    page_hold_a: assert property (
        PAGE_RX_FLAG && !rd_exp_low |=> PAGE_RX_FLAG)
        else $error("page flag dropped without a read");

    // The flag never rises without a page strobe
    flag_source_a: assert property (
        !PAGE_RX_STB && !PAGE_RX_FLAG |=> !PAGE_RX_FLAG)
        else $error("page flag set without a page");

    // A page in the clearing read cycle keeps the flag up
    set_over_clear_a: assert property (
        PAGE_RX_STB && rd_exp_low |=> PAGE_RX_FLAG)
        else $error("same-cycle read cleared a new page flag");

    // ------------------------------------------------------------
    // Assertions: extended status pair
    // ------------------------------------------------------------

    // Extended status reports constant capability bits
    ext_high_a: assert property (
        HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_EXT_HIGH
        |=> HOST_RDATA == 8'h80)
        else $error("extended high byte wrong");

    ext_low_a: assert property (
        HOST_REQ.wr && HOST_REQ.addr == ability_pkg::OFS_EXT_LOW
        ##1 HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_EXT_LOW
        |=> HOST_RDATA == 8'h00)
        else $error("extended low byte not zero after write");

    ext_low_read_a: assert property (
        HOST_REQ.rd && HOST_REQ.addr == ability_pkg::OFS_EXT_LOW
        |=> HOST_RDATA == 8'h00)
        else $error("extended low byte read not zero");

    // Page word and flag land in the same cycle
    partner_load_a: assert property (
        PAGE_RX_STB |=> PAGE_RX_FLAG
        && ability_pkg::pack_high(partner) ==
           ($past(PAGE_RX_WORD[15:8]) & ability_pkg::HIGH_FIELD_MASK)
        && ability_pkg::pack_low(partner) ==
           ($past(PAGE_RX_WORD[7:0]) & ability_pkg::LOW_FIELD_MASK))
        else $error("partner page not loaded with flag");

    // ------------------------------------------------------------
    // Cover points for the main scenarios
    // ------------------------------------------------------------
    page_then_read_c: cover property (
        PAGE_RX_STB ##[1:20] rd_exp_low);
    set_and_clear_c: cover property (
        PAGE_RX_STB && rd_exp_low);
    adv_write_read_c: cover property (
        wr_adv_high ##1 HOST_REQ.rd
        && HOST_REQ.addr == ability_pkg::OFS_ADV_HIGH);
    partner_write_c: cover property (
        HOST_REQ.wr && HOST_REQ.addr == ability_pkg::OFS_LP_LOW);
    page_burst_c: cover property (
        PAGE_RX_STB ##1 PAGE_RX_STB);

endmodule
`default_nettype wire

// [core/ability_pkg.sv]
`default_nettype none
package ability_pkg;

    // ------------------------------------------------------------
    // Register offsets on the host bus
    // ------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_ADV_LOW = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_ADV_HIGH = 5'h09;
    localparam logic [ADDR_W-1:0] OFS_LP_LOW = 5'h0A;
    localparam logic [ADDR_W-1:0] OFS_LP_HIGH = 5'h0B;
    localparam logic [ADDR_W-1:0] OFS_EXP_LOW = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_EXP_HIGH = 5'h0D;
    localparam logic [ADDR_W-1:0] OFS_EXT_LOW = 5'h1E;
    localparam logic [ADDR_W-1:0] OFS_EXT_HIGH = 5'h1F;

    // ------------------------------------------------------------
    // Field positions, high byte
    // ------------------------------------------------------------
    localparam int BIT_NP = 7;
    localparam int BIT_ACK = 6;
    localparam int BIT_RF_HI = 5;
    localparam int BIT_RF_LO = 4;
    localparam int BIT_PAUSE1 = 0;
    // Field positions, low byte
    localparam int BIT_PAUSE0 = 7;
    localparam int BIT_HALF = 6;
    localparam int BIT_FULL = 5;
    // Expansion low byte
    localparam int BIT_PAGE_RX = 1;
    // Extended status high byte
    localparam int BIT_1000X_FD = 7;

    // ------------------------------------------------------------
    // Constant and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] EXT_HIGH_VALUE = 8'h80;
    localparam logic [7:0] EXT_LOW_VALUE = 8'h00;
    localparam logic [7:0] EXP_HIGH_VALUE = 8'h00;
    localparam logic [7:0] HIGH_FIELD_MASK = 8'hF1;
    localparam logic [7:0] LOW_FIELD_MASK = 8'hE0;
    // Advertise full duplex only after reset
    localparam logic [7:0] ADV_HIGH_RESET = 8'h00;
    localparam logic [7:0] ADV_LOW_RESET = 8'h20;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic next_page;
        logic ack;
        logic [1:0] remote_fault;
        logic [1:0] pause;
        logic half_duplex;
        logic full_duplex;
    } ability_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } host_req_t;

    // ------------------------------------------------------------
    // Byte packing shared by all ability registers
    // ------------------------------------------------------------
    function automatic logic [7:0] pack_high(input ability_t a);
        logic [7:0] b;
        b = BYTE_ZERO;
        b[BIT_NP] = a.next_page;
        b[BIT_ACK] = a.ack;
        b[BIT_RF_HI] = a.remote_fault[1];
        b[BIT_RF_LO] = a.remote_fault[0];
        b[BIT_PAUSE1] = a.pause[1];
        return b;
    endfunction

    function automatic logic [7:0] pack_low(input ability_t a);
        logic [7:0] b;
        b = BYTE_ZERO;
        b[BIT_PAUSE0] = a.pause[0];
        b[BIT_HALF] = a.half_duplex;
        b[BIT_FULL] = a.full_duplex;
        return b;
    endfunction

    function automatic ability_t unpack(input logic [7:0] hi,
                                        input logic [7:0] lo);
        ability_t a;
        a.next_page = hi[BIT_NP];
        a.ack = hi[BIT_ACK];
        a.remote_fault = {hi[BIT_RF_HI], hi[BIT_RF_LO]};
        a.pause = {hi[BIT_PAUSE1], lo[BIT_PAUSE0]};
        a.half_duplex = lo[BIT_HALF];
        a.full_duplex = lo[BIT_FULL];
        return a;
    endfunction

endpackage
`default_nettype wire

// [core/page_flag.sv]
`timescale 1ns/10ps
`default_nettype none
module page_flag (
    input wire logic clock,
    input wire logic reset,
    input wire logic set_pulse,
    input wire logic clear_pulse,
    output logic flag
);

    logic flag_ff;

    // ------------------------------------------------------------
    // Sticky flag
    // ------------------------------------------------------------
    // Set beats clear so a page arriving during the read is not lost
    always_ff @(posedge clock) begin
        if (reset) begin
            flag_ff <= 1'b0;
        end else if (set_pulse) begin
            flag_ff <= 1'b1;
        end else if (clear_pulse) begin
            flag_ff <= 1'b0;
        end
    end

    assign flag = flag_ff;

endmodule
`default_nettype wire

// [core/partner_capture.sv]
`timescale 1ns/10ps
`default_nettype none
module partner_capture (
    input wire logic clock,
    input wire logic reset,
    input wire logic load,
    input wire logic [15:0] page_word,
    output ability_pkg::ability_t partner
);

    ability_pkg::ability_t partner_ff;

    // ------------------------------------------------------------
    // Partner base page capture
    // ------------------------------------------------------------
    // Only the field bits are kept, so unused bits can never read back
    always_ff @(posedge clock) begin
        if (reset) begin
            partner_ff <= ability_pkg::unpack(ability_pkg::BYTE_ZERO,
                                              ability_pkg::BYTE_ZERO);
        end else if (load) begin
            partner_ff <= ability_pkg::unpack(page_word[15:8],
                                              page_word[7:0]);
        end
    end

    assign partner = partner_ff;

endmodule
`default_nettype wire

// [bench/autoneg_ability_regs_test.sv]
`timescale 1ns/10ps
`default_nettype none
module autoneg_ability_regs_test;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic CLOCK = 1'b0;
    logic RESET = 1'b1;
    ability_pkg::host_req_t HOST_REQ = '0;
    logic PAGE_RX_STB = 1'b0;
    logic [15:0] PAGE_RX_WORD = 16'h0000;
    logic [7:0] HOST_RDATA;
    logic HOST_RVALID;
    ability_pkg::ability_t ADV_ABILITY;
    ability_pkg::ability_t PARTNER_ABILITY;
    logic PAGE_RX_FLAG;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] seed = 32'h4abc_fdec;
    logic [7:0] expq[$];
    // Mapped offsets first, then two unmapped ones
    logic [4:0] ofs_tab [10] = '{5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
                                 5'h1e, 5'h1f, 5'h05, 5'h00};
    logic [7:0] rst_tab [10] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h80, 8'h00, 8'h00};

    autoneg_ability_regs autoneg_ability_regs_inst (
        .CLOCK(CLOCK),
        .RESET(RESET),
        .HOST_REQ(HOST_REQ),
        .HOST_RDATA(HOST_RDATA),
        .HOST_RVALID(HOST_RVALID),
        .PAGE_RX_STB(PAGE_RX_STB),
        .PAGE_RX_WORD(PAGE_RX_WORD),
        .ADV_ABILITY(ADV_ABILITY),
        .PARTNER_ABILITY(PARTNER_ABILITY),
        .PAGE_RX_FLAG(PAGE_RX_FLAG)
    );

    // 20 MHz clock
    always #25 CLOCK = ~CLOCK;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Own field mapping, kept apart from the design's packing code
    function automatic logic [7:0] fields(input logic [7:0] hi,
                                          input logic [7:0] lo);
        return {hi[7], hi[6], hi[5:4], hi[0], lo[7], lo[6], lo[5]};
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] want,
                         input string what);
        num_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h want %h",
                     $time, what, seen, want);
        end
    endtask

    // One bus cycle from a falling edge; reads note their answer
    task automatic bus(input logic rd, input logic wr, input logic [4:0] a,
                       input logic [7:0] d, input logic [7:0] want);
        HOST_REQ = '{rd: rd, wr: wr, addr: a, wdata: d};
        if (rd) begin
            expq.push_back(want);
        end
        @(negedge CLOCK);
    endtask

    task automatic idle();
        HOST_REQ = '0;
        @(negedge CLOCK);
    endtask

    task automatic strobe(input logic [15:0] w);
        PAGE_RX_STB = 1'b1;
        PAGE_RX_WORD = w;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Read monitor: read data stands one cycle with the valid pulse
    // ------------------------------------------------------------
    always @(negedge CLOCK) begin
        if (HOST_RVALID === 1'b1) begin
            if (expq.size() == 0) begin
                mismatches++;
                $display("CHECK FAILED at %0t: unexpected read answer", $time);
            end else begin
                check(HOST_RDATA, expq.pop_front(), "read data");
            end
        end
    end

    // Hang guard
    initial begin
        #200000;
        mismatches++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin : main
        logic [31:0] r;
        logic [7:0] hi;
        logic [7:0] lo;
        repeat (4) @(negedge CLOCK);
        RESET = 1'b0;
        // Reset values, back-to-back reads incl. unmapped offsets
        check(ADV_ABILITY, fields(8'h00, 8'h20), "adv reset");
        check(PARTNER_ABILITY, 8'h00, "partner reset");
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 1'b0, ofs_tab[i], 8'h00, rst_tab[i]);
        end
        idle();
        $display("test reset values done");
        // Advertised pair: random writes, non-field bits dropped
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            hi = r[7:0];
            lo = r[15:8];
            // High write last, so its read-back follows directly
            bus(1'b0, 1'b1, 5'h08, lo, 8'h00);
            bus(1'b0, 1'b1, 5'h09, hi, 8'h00);
            check(ADV_ABILITY, fields(hi, lo), "adv port");
            bus(1'b1, 1'b0, 5'h09, 8'h00, hi & 8'hf1);
            bus(1'b1, 1'b0, 5'h08, 8'h00, lo & 8'he0);
        end
        idle();
        $display("test advertised writes done");
        // Writes to read-only places have no effect
        for (int i = 2; i < 8; i++) begin
            r = rnd();
            bus(1'b0, 1'b1, ofs_tab[i], r[7:0], 8'h00);
        end
        for (int i = 2; i < 8; i++) begin
            bus(1'b1, 1'b0, ofs_tab[i], 8'h00, rst_tab[i]);
        end
        bus(1'b0, 1'b1, 5'h1e, r[15:8], 8'h00);
        bus(1'b1, 1'b0, 5'h1e, 8'h00, 8'h00);
        bus(1'b1, 1'b0, 5'h09, 8'h00, hi & 8'hf1);
        idle();
        $display("test read-only writes done");
        // Page arrival, single then two back-to-back strobes
        for (int n = 1; n < 3; n++) begin
            for (int k = 0; k < n; k++) begin
                r = rnd();
                strobe(r[15:0]);
                @(negedge CLOCK);
            end
            PAGE_RX_STB = 1'b0;
            check({7'h00, PAGE_RX_FLAG}, 8'h01, "flag set");
            check(PARTNER_ABILITY, fields(r[15:8], r[7:0]), "partner");
            bus(1'b1, 1'b0, 5'h0b, 8'h00, r[15:8] & 8'hf1);
            bus(1'b1, 1'b0, 5'h0a, 8'h00, r[7:0] & 8'he0);
            bus(1'b1, 1'b0, 5'h0c, 8'h00, 8'h02);
            bus(1'b1, 1'b0, 5'h0c, 8'h00, 8'h00);
            idle();
            check({7'h00, PAGE_RX_FLAG}, 8'h00, "flag cleared");
        end
        $display("test page received done");
        // Strobe in the same cycle as a clearing read: set wins
        r = rnd();
        strobe(r[15:0]);
        bus(1'b1, 1'b0, 5'h0c, 8'h00, 8'h00);
        check({7'h00, PAGE_RX_FLAG}, 8'h01, "flag after clash");
        // Strobe stays up into the second clash; only the word changes
        strobe(r[31:16]);
        bus(1'b1, 1'b0, 5'h0c, 8'h00, 8'h02);
        PAGE_RX_STB = 1'b0;
        check({7'h00, PAGE_RX_FLAG}, 8'h01, "flag kept");
        check(PARTNER_ABILITY, fields(r[31:24], r[23:16]), "partner");
        bus(1'b1, 1'b0, 5'h0c, 8'h00, 8'h02);
        bus(1'b1, 1'b0, 5'h0c, 8'h00, 8'h00);
        idle();
        $display("test set against clear done");
        // Second reset in mid-run with the flag standing
        strobe(16'hffff);
        @(negedge CLOCK);
        PAGE_RX_STB = 1'b0;
        RESET = 1'b1;
        @(negedge CLOCK);
        RESET = 1'b0;
        check({7'h00, PAGE_RX_FLAG}, 8'h00, "flag after reset");
        check(PARTNER_ABILITY, 8'h00, "partner after reset");
        check(ADV_ABILITY, fields(8'h00, 8'h20), "adv after reset");
        bus(1'b1, 1'b0, 5'h08, 8'h00, 8'h20);
        bus(1'b1, 1'b0, 5'h0c, 8'h00, 8'h00);
        idle();
        $display("test second reset done");
        // Drain outstanding answers under a bound
        for (int i = 0; i < 10 && expq.size() != 0; i++) begin
            @(negedge CLOCK);
        end
        if (expq.size() != 0) begin
            mismatches++;
            $display("CHECK FAILED at %0t: read answers missing", $time);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
